/* File: hw/scd_command_decode.sv */
// sdram command decoder, bank and power state, byte masked data path
`timescale 1ns/10ps
`default_nettype none

module scd_command_decode #(
   parameter int unsigned BUF_DEPTH = scd_pkg::BUF_DEPTH
) (
   input  wire logic                 core_clk_in,
   input  wire logic                 reset_in,
   input  wire logic                 chip_select_n_in,
   input  wire logic                 row_strobe_n_in,
   input  wire logic                 col_strobe_n_in,
   input  wire logic                 write_strobe_n_in,
   input  wire logic                 clock_gate_in,
   input  wire logic                 bank_select_bit_in,
   input  wire logic                 precharge_flag_bit_in,
   input  wire logic [9:0]           row_column_address_in,
   input  wire logic                 upper_byte_mask_in,
   input  wire logic                 lower_byte_mask_in,
   input  wire logic [15:0]          data_lines_in,
   output logic [15:0]               data_lines_out,
   output logic [1:0]                data_lines_oe_out,
   input  wire logic                 burst_active_in,
   input  wire logic                 burst_is_read_in,
   input  wire logic                 rd_valid_in,
   input  wire logic [15:0]          rd_data_in,
   output logic                      cmd_valid_out,
   output scd_pkg::scd_cmd_t         cmd_out,
   output logic                      cmd_bank_out,
   output logic [9:0]                cmd_address_out,
   output logic [7:0]                cmd_column_out,
   output logic [1:0]                bank_active_out,
   output scd_pkg::scd_pstate_t      power_state_out,
   output logic                      wdat_valid_out,
   output logic [15:0]               wdat_data_out,
   output logic [1:0]                wdat_byte_en_out,
   input  wire logic                 wdat_ready_in,
   output logic                      wbuf_ready_out
);

   ////////////////////////////////////////////////////////////////////////
   // pin capture: the controller shares this clock, so one stage only

   logic        cs_n_ff;
   logic        ras_n_ff;
   logic        cas_n_ff;
   logic        we_n_ff;
   logic        cke_ff;
   logic        cke_prev_ff;
   logic        bank_ff;
   logic        ap_ff;
   logic [9:0]  addr_ff;
   logic [1:0]  mask_ff;
   logic [1:0]  mask_d1_ff;
   logic [15:0] din_ff;

   always_ff @(posedge core_clk_in) begin
      cs_n_ff  <= chip_select_n_in; // RL1
      ras_n_ff <= row_strobe_n_in;
      cas_n_ff <= col_strobe_n_in;
      we_n_ff  <= write_strobe_n_in;
      bank_ff  <= bank_select_bit_in;
      ap_ff    <= precharge_flag_bit_in;
      addr_ff  <= row_column_address_in;
      din_ff   <= data_lines_in; // RL19
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         cke_ff      <= 1'b0;
         cke_prev_ff <= 1'b0;
         mask_ff     <= 2'h3;
         mask_d1_ff  <= 2'h3;
      end else begin
         cke_ff      <= clock_gate_in;
         cke_prev_ff <= cke_ff; // RL14
         mask_ff     <= {upper_byte_mask_in, lower_byte_mask_in}; // RL18
         mask_d1_ff  <= mask_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command decode

   // strobe code is {ras_n, cas_n, we_n}; select high masks everything
   function automatic scd_pkg::scd_cmd_t decode_base(
      input logic       cs_n,
      input logic [2:0] code,
      input logic       ap
   );
      scd_pkg::scd_cmd_t c;
      c = scd_pkg::CMD_NOP;
      if (cs_n) begin
         c = scd_pkg::CMD_DESELECT; // RL20
      end else begin
         unique case (code)
            3'b011: c = scd_pkg::CMD_OPEN_ROW; // RL2
            3'b010: c = ap ? scd_pkg::CMD_CLOSE_ALL
                           : scd_pkg::CMD_CLOSE_BANK; // RL22
            3'b100: c = ap ? scd_pkg::CMD_WRITE_AP
                           : scd_pkg::CMD_WRITE; // RL3
            3'b101: c = ap ? scd_pkg::CMD_READ_AP
                           : scd_pkg::CMD_READ; // RL4
            3'b000: c = scd_pkg::CMD_MODE_LOAD; // RL5
            3'b110: c = scd_pkg::CMD_BURST_STOP; // RL7
            3'b001: c = scd_pkg::CMD_REFRESH; // RL9
            3'b111: c = scd_pkg::CMD_NOP; // RL6
         endcase
      end
      return c;
   endfunction

   scd_pkg::scd_cmd_t   base_cmd;
   scd_pkg::scd_cmd_t   nxt_cmd;
   scd_pkg::scd_pstate_t pstate_ff;
   scd_pkg::scd_pstate_t nxt_pstate;
   logic [1:0]          banks_ff;
   logic [1:0]          nxt_banks;
   logic                quiet;
   logic                all_idle;
   logic [1:0]          sel_bank;

   assign base_cmd = decode_base(cs_n_ff, {ras_n_ff, cas_n_ff, we_n_ff},
                                 ap_ff);
   assign quiet    = (base_cmd == scd_pkg::CMD_DESELECT) ||
                     (base_cmd == scd_pkg::CMD_NOP);
   assign all_idle = (banks_ff == 2'h0);
   assign sel_bank = bank_ff ? 2'h2 : 2'h1;

   always_comb begin
      nxt_cmd    = scd_pkg::CMD_NOP;
      nxt_pstate = pstate_ff;
      nxt_banks  = banks_ff;
      unique case (pstate_ff)
         scd_pkg::PS_RUN: begin
            if (cke_prev_ff && !cke_ff) begin // RL14
               if (base_cmd == scd_pkg::CMD_REFRESH && all_idle) begin
                  nxt_cmd    = scd_pkg::CMD_SELF_REF_ENTRY; // RL9
                  nxt_pstate = scd_pkg::PS_SELF_REF;
               end else if (!all_idle || burst_active_in) begin
                  // burst wins over power-down request
                  nxt_cmd    = scd_pkg::CMD_SUSPEND_ENTRY; // RL11 RL13
                  nxt_pstate = scd_pkg::PS_SUSPEND;
               end else if (quiet) begin
                  nxt_cmd    = scd_pkg::CMD_PDOWN_ENTRY; // RL12
                  nxt_pstate = scd_pkg::PS_PDOWN;
               end
            end else if (cke_prev_ff) begin
               nxt_cmd = base_cmd;
               unique case (base_cmd)
                  scd_pkg::CMD_OPEN_ROW: begin
                     if ((banks_ff & sel_bank) == 2'h0) begin
                        nxt_banks = banks_ff | sel_bank; // RL2
                     end else begin
                        nxt_cmd = scd_pkg::CMD_NOP; // RL23
                     end
                  end
                  scd_pkg::CMD_CLOSE_BANK:
                     nxt_banks = banks_ff & ~sel_bank; // RL22
                  scd_pkg::CMD_CLOSE_ALL:
                     nxt_banks = scd_pkg::BANKS_RESET; // RL22
                  scd_pkg::CMD_WRITE, scd_pkg::CMD_READ: begin
                     if ((banks_ff & sel_bank) == 2'h0) begin
                        nxt_cmd = scd_pkg::CMD_NOP; // RL23
                     end
                  end
                  scd_pkg::CMD_WRITE_AP, scd_pkg::CMD_READ_AP: begin
                     // bank marked idle at once; precharge timing is elsewhere
                     if ((banks_ff & sel_bank) == 2'h0) begin
                        nxt_cmd = scd_pkg::CMD_NOP; // RL23
                     end else begin
                        nxt_banks = banks_ff & ~sel_bank;
                     end
                  end
                  scd_pkg::CMD_MODE_LOAD, scd_pkg::CMD_REFRESH: begin
                     if (!all_idle) begin
                        nxt_cmd = scd_pkg::CMD_NOP; // RL5 RL9
                     end
                  end
                  scd_pkg::CMD_BURST_STOP: begin
                     if (!burst_active_in) begin
                        nxt_cmd = scd_pkg::CMD_NOP; // RL7 RL8
                     end
                  end
                  default: ;
               endcase
            end
            // clock gate low in the previous cycle without entry: no command
         end
         scd_pkg::PS_SUSPEND: begin
            if (!cke_prev_ff && cke_ff) begin
               nxt_cmd    = scd_pkg::CMD_SUSPEND_EXIT; // RL11
               nxt_pstate = scd_pkg::PS_RUN;
            end
         end
         scd_pkg::PS_PDOWN: begin
            if (!cke_prev_ff && cke_ff && quiet) begin
               nxt_cmd    = scd_pkg::CMD_PDOWN_EXIT; // RL12
               nxt_pstate = scd_pkg::PS_RUN;
            end
         end
         scd_pkg::PS_SELF_REF: begin
            if (!cke_prev_ff && cke_ff && quiet) begin
               nxt_cmd    = scd_pkg::CMD_SELF_REF_EXIT; // RL10
               nxt_pstate = scd_pkg::PS_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         pstate_ff <= scd_pkg::PS_RUN;
         banks_ff  <= scd_pkg::BANKS_RESET;
      end else begin
         pstate_ff <= nxt_pstate;
         banks_ff  <= nxt_banks;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         cmd_valid_out   <= 1'b0;
         cmd_out         <= scd_pkg::CMD_NOP;
         cmd_bank_out    <= 1'b0;
         cmd_address_out <= 10'h000;
         cmd_column_out  <= 8'h00;
      end else begin
         // nop and deselect start nothing, so no strobe for them
         cmd_valid_out   <= (nxt_cmd != scd_pkg::CMD_NOP) &&
                            (nxt_cmd != scd_pkg::CMD_DESELECT); // RL6 RL24
         cmd_out         <= nxt_cmd;
         cmd_bank_out    <= bank_ff;
         cmd_address_out <= addr_ff;
         cmd_column_out  <= addr_ff[7:0]; // RL21
      end
   end

   assign bank_active_out = banks_ff;
   assign power_state_out = pstate_ff;

   ////////////////////////////////////////////////////////////////////////
   // write path: fully masked beats dropped, then two-entry buffer

   logic        running;
   logic        wr_beat;
   logic        push;
   logic        pop;
   logic [17:0] buf_mem [BUF_DEPTH];
   logic        wptr_ff;
   logic        rptr_ff;
   logic [1:0]  count_ff;

   assign running = (pstate_ff == scd_pkg::PS_RUN) && cke_prev_ff;
   // data is taken with the write command itself and on each write burst beat
   assign wr_beat = running &&
                    ((nxt_cmd == scd_pkg::CMD_WRITE) ||
                     (nxt_cmd == scd_pkg::CMD_WRITE_AP) ||
                     (burst_active_in && !burst_is_read_in));
   assign push    = wr_beat && (mask_ff != 2'h3) &&
                    (count_ff != 2'(BUF_DEPTH)); // RL16
   assign pop     = (count_ff != 2'h0) && wdat_ready_in;
   assign wbuf_ready_out = (count_ff != 2'(BUF_DEPTH));

   always_ff @(posedge core_clk_in) begin
      if (push) begin
         buf_mem[wptr_ff] <= {~mask_ff, din_ff}; // RL15 RL16
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         wptr_ff  <= 1'b0;
         rptr_ff  <= 1'b0;
         count_ff <= 2'h0;
      end else begin
         if (push) begin
            wptr_ff <= ~wptr_ff;
         end
         if (pop) begin
            rptr_ff <= ~rptr_ff;
         end
         count_ff <= 2'(count_ff + {1'b0, push} - {1'b0, pop});
      end
   end

   assign wdat_valid_out   = (count_ff != 2'h0);
   assign wdat_data_out    = buf_mem[rptr_ff][15:0];
   assign wdat_byte_en_out = buf_mem[rptr_ff][17:16];

   ////////////////////////////////////////////////////////////////////////
   // read path: mask sampled at edge n gates the byte driven from edge n+2

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         data_lines_out    <= scd_pkg::DATA_RESET;
         data_lines_oe_out <= scd_pkg::OE_RESET;
      end else if (pstate_ff == scd_pkg::PS_RUN) begin
         // output frozen while suspended
         data_lines_out    <= rd_data_in; // RL19
         data_lines_oe_out <= {2{rd_valid_in && burst_is_read_in}} &
                              ~mask_d1_ff; // RL17 RL18
      end else if (pstate_ff != scd_pkg::PS_SUSPEND) begin
         data_lines_oe_out <= scd_pkg::OE_RESET;
      end
   end

endmodule

`default_nettype wire

/* File: include/scd_pkg.sv */
// constants and types for the sdram command decoder and byte mask logic
//
// Contract
// RL1 - all command, address and control pins are captured on the rising edge only.
// RL2 - clock gate high before, select low: row low opens row; write low closes bank.
// RL3 - row high, column low, write low starts write; precharge bit adds auto precharge.
// RL4 - row high, column low, write high starts read; precharge bit adds auto precharge.
// RL5 - select and all strobes low loads mode register; only while banks idle.
// RL6 - select high deselects; select low with strobes high is no operation.
// RL7 - row and column high, write low is burst stop, valid only during a burst.
// RL8 - burst stop works for single, two, four, eight and full page bursts.
// RL9 - idle banks, refresh code: clock gate high refreshes, gate low enters self refresh.
// RL10 - self refresh ends when clock gate rises with deselect or no operation.
// RL11 - active bank and clock gate falling enters suspend; gate rising leaves it.
// RL12 - gate falling with deselect or nop enters power-down; rising leaves it.
// RL13 - power-down request during a burst gives clock suspend instead.
// RL14 - each command is classified using clock gate now and one cycle earlier.
// RL15 - byte masks act per byte, only when sampled; high puts that byte in high-z.
// RL16 - masked write bytes are discarded, leaving stored data unchanged.
// RL17 - read byte mask suppresses that output byte two clocks later.
// RL18 - upper mask governs data bits 15 to 8, lower mask bits 7 to 0.
// RL19 - sixteen data lines move write and read data on rising edges, both maskable.
// RL20 - all command inputs are ignored while chip select is sampled high.
// RL21 - read and write take column from address bits 7 to 0.
// RL22 - precharge bit high closes both banks, else bank select picks one.
// RL23 - controller issues each command only in a bank state that allows it.
// RL24 - undefined input combinations act as no operation, no bank state change.
package scd_pkg;

   localparam int unsigned DATA_WIDTH   = 16;
   localparam int unsigned ADDR_WIDTH   = 10;
   localparam int unsigned COL_WIDTH    = 8;
   localparam int unsigned NUM_BANKS    = 2;
   localparam int unsigned MASK_LATENCY = 2;
   localparam int unsigned BUF_DEPTH    = 2;
   localparam logic [1:0]  BANKS_RESET  = 2'h0;
   localparam logic [1:0]  OE_RESET     = 2'h0;
   localparam logic [15:0] DATA_RESET   = 16'h0000;

   typedef enum logic [4:0] {
      CMD_NOP            = 5'b00000,
      CMD_DESELECT       = 5'b00001,
      CMD_OPEN_ROW       = 5'b00010,
      CMD_CLOSE_BANK     = 5'b00011,
      CMD_CLOSE_ALL      = 5'b00100,
      CMD_WRITE          = 5'b00101,
      CMD_WRITE_AP       = 5'b00110,
      CMD_READ           = 5'b00111,
      CMD_READ_AP        = 5'b01000,
      CMD_MODE_LOAD      = 5'b01001,
      CMD_BURST_STOP     = 5'b01010,
      CMD_REFRESH        = 5'b01011,
      CMD_SELF_REF_ENTRY = 5'b01100,
      CMD_SELF_REF_EXIT  = 5'b01101,
      CMD_SUSPEND_ENTRY  = 5'b01110,
      CMD_SUSPEND_EXIT   = 5'b01111,
      CMD_PDOWN_ENTRY    = 5'b10000,
      CMD_PDOWN_EXIT     = 5'b10001
   } scd_cmd_t;

   typedef enum logic [1:0] {
      PS_RUN      = 2'b00,
      PS_SUSPEND  = 2'b01,
      PS_PDOWN    = 2'b10,
      PS_SELF_REF = 2'b11
   } scd_pstate_t;

endpackage

/* File: test/scd_command_decode_properties.sv */
// concurrent checks on the command decoder and byte mask ports
`timescale 1ns/10ps
`default_nettype none
module scd_command_decode_properties (
   input wire logic                 core_clk_in,
   input wire logic                 reset_in,
   input wire logic                 chip_select_n_in,
   input wire logic                 row_strobe_n_in,
   input wire logic                 col_strobe_n_in,
   input wire logic                 write_strobe_n_in,
   input wire logic                 clock_gate_in,
   input wire logic                 bank_select_bit_in,
   input wire logic                 precharge_flag_bit_in,
   input wire logic                 upper_byte_mask_in,
   input wire logic                 lower_byte_mask_in,
   input wire logic                 burst_is_read_in,
   input wire logic                 rd_valid_in,
   input wire logic [15:0]          rd_data_in,
   input wire logic [15:0]          data_lines_out,
   input wire logic [1:0]           data_lines_oe_out,
   input wire logic                 cmd_valid_out,
   input wire scd_pkg::scd_cmd_t    cmd_out,
   input wire logic [1:0]           bank_active_out,
   input wire scd_pkg::scd_pstate_t power_state_out,
   input wire logic                 wdat_valid_out,
   input wire logic [15:0]          wdat_data_out,
   input wire logic [1:0]           wdat_byte_en_out,
   input wire logic                 wdat_ready_in
);
   logic [1:0] up_ff;
   logic       gate_d_ff;
   logic [3:0] c;
   logic       ok;
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (reset_in);
   ////////////////////////////////////////////////////////////////////////
   // gate history is unknown to us for the first edges after reset
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         up_ff <= 2'h0;
      end else if (up_ff != 2'h3) begin
         up_ff <= up_ff + 2'h1;
      end
   end
   always_ff @(posedge core_clk_in) begin
      gate_d_ff <= clock_gate_in;
   end
   assign c = {chip_select_n_in, row_strobe_n_in, col_strobe_n_in,
               write_strobe_n_in};
   assign ok = up_ff == 2'h3 && clock_gate_in && gate_d_ff &&
               power_state_out == scd_pkg::PS_RUN;
   ////////////////////////////////////////////////////////////////////////
   property p_open;
      ok && c == 4'h3 && !bank_select_bit_in ##1 !bank_active_out[0] |->
         ##1 cmd_valid_out && cmd_out == scd_pkg::CMD_OPEN_ROW &&
         bank_active_out[0];
   endproperty
   a_open: assert property (p_open) else $error("open row missed");
   property p_close_all;
      ok && c == 4'h2 && precharge_flag_bit_in |->
         ##2 bank_active_out == 2'h0 && cmd_out == scd_pkg::CMD_CLOSE_ALL;
   endproperty
   a_close_all: assert property (p_close_all) else $error("close all");
   property p_write;
      ok && c == 4'h4 && !precharge_flag_bit_in && !bank_select_bit_in
         ##1 bank_active_out[0] |-> ##1 cmd_out == scd_pkg::CMD_WRITE;
   endproperty
   a_write: assert property (p_write) else $error("write missed");
   property p_nop;
      ok && (chip_select_n_in || c == 4'h7) |-> ##2 !cmd_valid_out;
   endproperty
   a_nop: assert property (p_nop) else $error("idle cycle decoded");
   property p_self;
      up_ff == 2'h3 && gate_d_ff && !clock_gate_in && c == 4'h1 &&
         power_state_out == scd_pkg::PS_RUN ##1 bank_active_out == 2'h0
         |-> ##1 power_state_out == scd_pkg::PS_SELF_REF;
   endproperty
   a_self: assert property (p_self) else $error("no self refresh");
   property p_exit;
      up_ff == 2'h3 && !gate_d_ff && clock_gate_in && chip_select_n_in
         ##1 power_state_out != scd_pkg::PS_RUN
         |-> ##1 power_state_out == scd_pkg::PS_RUN;
   endproperty
   a_exit: assert property (p_exit) else $error("no power exit");
   property p_rmask;
      ok && upper_byte_mask_in ##1 clock_gate_in [*2]
         |-> ##1 !data_lines_oe_out[1];
   endproperty
   a_rmask: assert property (p_rmask) else $error("upper not masked");
   property p_rdata;
      ok && !lower_byte_mask_in ##2 ok && rd_valid_in && burst_is_read_in
         |-> ##1 data_lines_oe_out[0] && data_lines_out == $past(rd_data_in);
   endproperty
   a_rdata: assert property (p_rdata) else $error("read beat lost");
   property p_hold;
      wdat_valid_out && !wdat_ready_in |=> wdat_valid_out &&
         $stable(wdat_data_out) && $stable(wdat_byte_en_out);
   endproperty
   a_hold: assert property (p_hold) else $error("stalled head moved");
   c_open: cover property (c == 4'h3 ##2 cmd_valid_out);
   c_self: cover property (power_state_out == scd_pkg::PS_SELF_REF);
   c_stall: cover property (wdat_valid_out && !wdat_ready_in);
endmodule
bind scd_command_decode scd_command_decode_properties
   u_scd_command_decode_properties (.*);
`default_nettype wire

/* File: test/scd_wdat_sink.sv */
// write data sink on the far side of the buffer, stalls on request
`timescale 1ns/10ps
`default_nettype none
module scd_wdat_sink (
   input  wire logic       core_clk_in,
   input  wire logic       reset_in,
   input  wire logic       stall_in,
   input  wire logic       wdat_valid_in,
   output logic            wdat_ready_out,
   output logic [3:0]      pops_out
);
   // a stall is the only way to fill the buffer from the pins side
   assign wdat_ready_out = !stall_in;
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         pops_out <= 4'h0;
      end else if (wdat_valid_in && wdat_ready_out) begin
         pops_out <= pops_out + 4'h1;
      end
   end
endmodule
`default_nettype wire

/* File: test/test_scd_command_decode.sv */
// self-checking bench for the command decoder and byte mask logic
`timescale 1ns/10ps
`default_nettype none
module test_scd_command_decode;
   logic                 core_clk_in = 1'b0;
   logic                 reset_in = 1'b1;
   logic [3:0]           cmd_pins = 4'h7;
   logic                 gate = 1'b1, bsel = 1'b0, ap = 1'b0;
   logic                 umask = 1'b1, lmask = 1'b1, stall = 1'b1;
   logic                 burst = 1'b0, is_rd = 1'b0, rd_vld = 1'b0;
   logic [15:0]          din = 16'h0000, rdat = 16'h0000, dout, wdata;
   logic [1:0]           oe, banks, wen;
   logic                 cvalid, wvalid, wready, wbuf_rdy, cbank;
   logic [9:0]           addr = 10'h2A5, caddr;
   logic [7:0]           col;
   logic [3:0]           pops;
   scd_pkg::scd_cmd_t    cmd;
   scd_pkg::scd_pstate_t ps;
   int                   bad_count = 0, comparisons = 0, cycles = 0;
   ////////////////////////////////////////////////////////////////////////
   scd_command_decode u_scd_command_decode (
      .core_clk_in(core_clk_in), .reset_in(reset_in),
      .chip_select_n_in(cmd_pins[3]), .row_strobe_n_in(cmd_pins[2]),
      .col_strobe_n_in(cmd_pins[1]), .write_strobe_n_in(cmd_pins[0]),
      .clock_gate_in(gate), .bank_select_bit_in(bsel),
      .precharge_flag_bit_in(ap), .row_column_address_in(addr),
      .upper_byte_mask_in(umask), .lower_byte_mask_in(lmask),
      .data_lines_in(din), .data_lines_out(dout), .data_lines_oe_out(oe),
      .burst_active_in(burst), .burst_is_read_in(is_rd),
      .rd_valid_in(rd_vld), .rd_data_in(rdat), .cmd_valid_out(cvalid),
      .cmd_out(cmd), .cmd_bank_out(cbank), .cmd_address_out(caddr),
      .cmd_column_out(col), .bank_active_out(banks), .power_state_out(ps),
      .wdat_valid_out(wvalid), .wdat_data_out(wdata),
      .wdat_byte_en_out(wen), .wdat_ready_in(wready),
      .wbuf_ready_out(wbuf_rdy));
   scd_wdat_sink u_scd_wdat_sink (
      .core_clk_in(core_clk_in), .reset_in(reset_in), .stall_in(stall),
      .wdat_valid_in(wvalid), .wdat_ready_out(wready), .pops_out(pops));
   always #50 core_clk_in = ~core_clk_in;
   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // a hang must still reach the verdict
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 1000) begin
         bad_count++;
         end_sim();
      end
   end
   task automatic check(input string name, input logic [15:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask
   // one command cycle, then nop; answer one edge after capture
   task automatic issue(input logic [3:0] c, input logic b, a,
         input scd_pkg::scd_cmd_t exp, input logic [1:0] eb);
      tick(1);
      cmd_pins <= c;
      bsel <= b;
      ap <= a;
      tick(1);
      cmd_pins <= 4'h7;
      tick(1);
      #1;
      check("cmd", cmd, exp);
      check("valid", cvalid, exp > scd_pkg::CMD_DESELECT);
      check("banks", banks, eb);
      check("bank", cbank, b);
   endtask
   task automatic gstep(input logic g, input logic [3:0] c,
         input scd_pkg::scd_pstate_t e);
      tick(1);
      gate <= g;
      cmd_pins <= c;
      tick(1);
      cmd_pins <= 4'h7;
      tick(1);
      #1;
      check("power", ps, e);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_cmds();
      issue(4'h3, 1'b0, 1'b0, scd_pkg::CMD_OPEN_ROW, 2'h1);
      issue(4'h3, 1'b0, 1'b0, scd_pkg::CMD_NOP, 2'h1);
      issue(4'h4, 1'b0, 1'b0, scd_pkg::CMD_WRITE, 2'h1);
      check("column", col, 8'hA5);
      addr <= 10'h15A;
      issue(4'h5, 1'b0, 1'b0, scd_pkg::CMD_READ, 2'h1);
      check("column", col, 8'h5A);
      check("address", caddr, 10'h15A);
      issue(4'h0, 1'b0, 1'b0, scd_pkg::CMD_NOP, 2'h1);
      issue(4'h6, 1'b0, 1'b0, scd_pkg::CMD_NOP, 2'h1);
      issue(4'h8, 1'b1, 1'b1, scd_pkg::CMD_DESELECT, 2'h1);
      issue(4'h5, 1'b0, 1'b1, scd_pkg::CMD_READ_AP, 2'h0);
      issue(4'h3, 1'b1, 1'b0, scd_pkg::CMD_OPEN_ROW, 2'h2);
      issue(4'h4, 1'b1, 1'b1, scd_pkg::CMD_WRITE_AP, 2'h0);
      issue(4'h3, 1'b1, 1'b0, scd_pkg::CMD_OPEN_ROW, 2'h2);
      issue(4'h3, 1'b0, 1'b0, scd_pkg::CMD_OPEN_ROW, 2'h3);
      issue(4'h2, 1'b1, 1'b0, scd_pkg::CMD_CLOSE_BANK, 2'h1);
      issue(4'h2, 1'b1, 1'b1, scd_pkg::CMD_CLOSE_ALL, 2'h0);
      issue(4'h0, 1'b0, 1'b0, scd_pkg::CMD_MODE_LOAD, 2'h0);
      issue(4'h1, 1'b0, 1'b0, scd_pkg::CMD_REFRESH, 2'h0);
      is_rd <= 1'b1;
      burst <= 1'b1;
      issue(4'h6, 1'b0, 1'b0, scd_pkg::CMD_BURST_STOP, 2'h0);
      $display("commands test done");
   endtask
   task automatic t_power();
      gstep(1'b0, 4'h7, scd_pkg::PS_SUSPEND);
      gstep(1'b1, 4'h7, scd_pkg::PS_RUN);
      burst <= 1'b0;
      gstep(1'b0, 4'h1, scd_pkg::PS_SELF_REF);
      gstep(1'b1, 4'h8, scd_pkg::PS_RUN);
      gstep(1'b0, 4'h7, scd_pkg::PS_PDOWN);
      gstep(1'b1, 4'h7, scd_pkg::PS_RUN);
      issue(4'h3, 1'b0, 1'b0, scd_pkg::CMD_OPEN_ROW, 2'h1);
      gstep(1'b0, 4'h5, scd_pkg::PS_SUSPEND);
      gstep(1'b1, 4'h4, scd_pkg::PS_RUN);
      $display("power test done");
   endtask
   task automatic t_write();
      is_rd <= 1'b0;
      burst <= 1'b1;
      din <= 16'h1234;
      {umask, lmask} <= 2'b00;
      tick(1);
      din <= 16'h5678;
      {umask, lmask} <= 2'b01;
      tick(1);
      {umask, lmask} <= 2'b11;
      tick(1);
      {umask, lmask} <= 2'b10;
      tick(1);
      burst <= 1'b0;
      tick(1);
      #1;
      check("full", wbuf_rdy, 1'b0);
      check("head", wdata, 16'h1234);
      check("en", wen, 2'b11);
      tick(1);
      stall <= 1'b0;
      tick(1);
      stall <= 1'b1;
      #1;
      check("head", wdata, 16'h5678);
      check("en", wen, 2'b10);
      stall <= 1'b0;
      tick(2);
      #1;
      check("empty", wvalid, 1'b0);
      check("pops", pops, 4'h2);
      $display("write test done");
   endtask
   task automatic t_read();
      is_rd <= 1'b1;
      burst <= 1'b1;
      rd_vld <= 1'b1;
      // masks left over from the write test would gate the first beats
      {umask, lmask} <= 2'b00;
      rdat <= 16'hC3A5;
      tick(3);
      #1;
      check("oe", oe, 2'b11);
      check("dout", dout, 16'hC3A5);
      for (int i = 1; i < 3; i++) begin
         tick(1);
         {umask, lmask} <= i[1:0];
         tick(1);
         {umask, lmask} <= 2'b00;
         tick(2);
         #1;
         check("oe", oe, 2'(~i[1:0]));
      end
      rd_vld <= 1'b0;
      burst <= 1'b0;
      $display("read test done");
   endtask
   initial begin
      tick(6);
      reset_in <= 1'b0;
      tick(3);
      #1;
      check("ready", wbuf_rdy, 1'b1);
      t_cmds();
      t_power();
      t_write();
      t_read();
      end_sim();
   end
endmodule
`default_nettype wire
